// >>> rtl/pwmtc_consts.svh
/*
  Timing figures shared by both ends of the mark-space link.
  Assumes a single 100 MHz clock at both ends.
*/
`ifndef PWMTC_CONSTS_SVH
`define PWMTC_CONSTS_SVH

// Clock period in nanoseconds.
`define PWMTC_CLK_PERIOD_NS 10

// Milliseconds to clock cycles.
`define PWMTC_MS_TO_CYC(ms) ((ms) * 1000000 / `PWMTC_CLK_PERIOD_NS)

// High periods per rate setting, in milliseconds.
`define PWMTC_TH_QTR_MS 10
`define PWMTC_TH_NOM_MS 40
`define PWMTC_TH_DBL_MS 80
`define PWMTC_TH_QTR_CYC `PWMTC_MS_TO_CYC(`PWMTC_TH_QTR_MS)
`define PWMTC_TH_NOM_CYC `PWMTC_MS_TO_CYC(`PWMTC_TH_NOM_MS)
`define PWMTC_TH_DBL_CYC `PWMTC_MS_TO_CYC(`PWMTC_TH_DBL_MS)

// Power-down delay after a steady high chain input, in milliseconds.
`define PWMTC_PD_MS 300
`define PWMTC_PD_CYC `PWMTC_MS_TO_CYC(`PWMTC_PD_MS)

// Start pulse emitted downstream, in microseconds.
`define PWMTC_START_OUT_US 17
`define PWMTC_START_OUT_CYC (`PWMTC_START_OUT_US * 1000 / `PWMTC_CLK_PERIOD_NS)

// Accepted start pulse width: at least 20 ns, shorter than 25 us.
`define PWMTC_START_MIN_NS 20
`define PWMTC_START_MIN_CYC ((`PWMTC_START_MIN_NS + 9) / `PWMTC_CLK_PERIOD_NS)
`define PWMTC_START_MAX_US 25
`define PWMTC_START_MAX_CYC (`PWMTC_START_MAX_US * 1000 / `PWMTC_CLK_PERIOD_NS)

// Host start pulse in microseconds, and its low lead-in in cycles.
`define PWMTC_HOST_PULSE_US 1
`define PWMTC_HOST_PULSE_CYC (`PWMTC_HOST_PULSE_US * 1000 / `PWMTC_CLK_PERIOD_NS)
`define PWMTC_HOST_PRE_CYC 2

// Single-shot pull-low time in nanoseconds, above the minimum.
`define PWMTC_PULL_NS 30
`define PWMTC_PULL_CYC ((`PWMTC_PULL_NS + 9) / `PWMTC_CLK_PERIOD_NS)

`endif

// >>> rtl/pwmtc_pkg.sv
/*
  Types for the mark-space link: pin codes and state encodings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pwmtc_pkg;

  // Three-level pin reading: low, floating, high.
  typedef enum logic [1:0] {
    PWMTC_PIN_LO = 2'h0,
    PWMTC_PIN_FL = 2'h1,
    PWMTC_PIN_HI = 2'h2
  } pwmtc_pin_t;

  // Sensor states, one-hot.
  typedef enum logic [4:0] {
    PWMTC_S_IDLE  = 5'h01,
    PWMTC_S_HIGH  = 5'h02,
    PWMTC_S_LOW   = 5'h04,
    PWMTC_S_START = 5'h08,
    PWMTC_S_PASS  = 5'h10
  } pwmtc_sstate_t;

  // Host states, one-hot.
  typedef enum logic [4:0] {
    PWMTC_H_IDLE  = 5'h01,
    PWMTC_H_PULL  = 5'h02,
    PWMTC_H_PRE   = 5'h04,
    PWMTC_H_PULSE = 5'h08,
    PWMTC_H_WAIT  = 5'h10
  } pwmtc_hstate_t;

endpackage

// >>> rtl/pwmtc_if.sv
/*
  Link between one sensor and its host: line, mode strap and rate or chain input.
  Assumes a pull-up; the line is low while any enabled driver drives low.
*/
`timescale 1ns/1ns
interface pwmtc_if;
  logic                   dev_out;
  logic                   dev_oe;
  logic                   host_out;
  logic                   host_oe;
  pwmtc_pkg::pwmtc_pin_t  op_mode_sel;
  pwmtc_pkg::pwmtc_pin_t  rate_sel_chain_in;
  logic                   line;

  // Resolves the pulled-up output line from both drivers.
  assign line = !((dev_oe && !dev_out) || (host_oe && !host_out));

  modport sensor (input op_mode_sel, input rate_sel_chain_in, input line,
                  output dev_out, output dev_oe);
  modport host (input line, output host_out, output host_oe,
                output op_mode_sel, output rate_sel_chain_in);
endinterface

// >>> rtl/pwmtc_sensor.sv
/*
  Sensor end: latches straps, emits waveforms, relays and
  extends the chain waveform.
  Assumes the modulator supplies the low period at the nominal rate in clock cycles,
  and that all pins are synchronous to clock.
*/
`timescale 1ns/1ns
`include "pwmtc_consts.svh"

// Summary of operation
// - Rate strap latched at power-up picks periods.
// - Host decodes 421 minus 751 times ratio.
// - Host decodes doubled-high rate with 93.875.
// - Low period grows with temperature, nominal rates.
// - Doubled-high rate uses quartered low period.
// - Mode high makes rate pin chain input.
// - Chain operation always uses nominal rate.
// - Host start pulse 20 ns to 25 us.
// - Start pulse triggers reading, then downstream pulse.
// - Downstream start pulse about 17 us wide.
// - Untriggered chain device passes input through.
// - Detect upstream pulse, append reading, insert pulse.
// - Host holds chain input low during readout.
// - Steady high input powers down; needs restart.
// - Host keeps chain input high when idle.
// - Mode strap: low single, float continuous, high chain.
// - Host low pulse starts one single-shot waveform.
// - High period fixed; only low period varies.
module pwmtc_sensor #(
  parameter int unsigned TH_QTR_CYC = `PWMTC_TH_QTR_CYC,
  parameter int unsigned TH_NOM_CYC = `PWMTC_TH_NOM_CYC,
  parameter int unsigned TH_DBL_CYC = `PWMTC_TH_DBL_CYC,
  parameter int unsigned PD_CYC     = `PWMTC_PD_CYC
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Link to host or neighbouring devices.
  pwmtc_if.sensor               link,
  // Modulator result: low period at nominal rate, in cycles.
  input  wire logic [31:0]      temp_tl_nom,
  // Status.
  output pwmtc_pkg::pwmtc_pin_t mode_seen,
  output pwmtc_pkg::pwmtc_pin_t rate_seen,
  output logic                  converting,
  output logic                  powered_down
);
  import pwmtc_pkg::*;

  localparam logic [31:0] START_OUT_CYC = 32'(`PWMTC_START_OUT_CYC);
  localparam logic [31:0] START_MIN_CYC = 32'(`PWMTC_START_MIN_CYC);
  localparam logic [31:0] START_MAX_CYC = 32'(`PWMTC_START_MAX_CYC);
  localparam logic [31:0] CNT_MAX       = 32'hffff_ffff;

  //////////////////////////////////////////////////////////////////////////////
  // State.

  logic           strap_done_reg;
  logic           strap_done_next;
  pwmtc_pin_t     mode_reg;
  pwmtc_pin_t     mode_next;
  pwmtc_pin_t     rate_reg;
  pwmtc_pin_t     rate_next;
  pwmtc_sstate_t  state_reg;
  pwmtc_sstate_t  state_next;
  logic [31:0]    cnt_reg;
  logic [31:0]    cnt_next;
  logic [31:0]    tl_reg;
  logic [31:0]    tl_next;
  logic [31:0]    width_reg;
  logic [31:0]    width_next;
  logic [31:0]    pd_cnt_reg;
  logic [31:0]    pd_cnt_next;
  logic           pd_reg;
  logic           pd_next;
  logic           out_reg;
  logic           out_next;
  logic           oe_reg;
  logic           oe_next;
  logic           in_q_reg;
  logic           in_q_next;
  logic           conv_reg;
  logic           conv_next;

  logic           chain_lvl;
  logic           is_chain;
  logic [31:0]    th_cyc;
  logic [31:0]    tl_scaled;

  //////////////////////////////////////////////////////////////////////////////
  // Period selection.

  // Chain level, chain flag and periods for the latched rate.
  always_comb
  begin
    chain_lvl = (link.rate_sel_chain_in == PWMTC_PIN_HI);
    is_chain  = (mode_reg == PWMTC_PIN_HI);
    // High period depends on rate and chain mode only, never on temperature.
    if (is_chain || rate_reg == PWMTC_PIN_FL)
    begin
      th_cyc    = TH_NOM_CYC;
      tl_scaled = temp_tl_nom;
    end
    else if (rate_reg == PWMTC_PIN_LO)
    begin
      th_cyc    = TH_QTR_CYC;
      tl_scaled = {2'h0, temp_tl_nom[31:2]};
    end
    else
    begin
      th_cyc    = TH_DBL_CYC;
      tl_scaled = {2'h0, temp_tl_nom[31:2]};
    end
    if (tl_scaled == 32'h0000_0000)
    begin
      tl_scaled = 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer next state.

  // Computes the next values of straps, sequencer, counters and outputs.
  always_comb
  begin
    strap_done_next = strap_done_reg;
    mode_next       = mode_reg;
    rate_next       = rate_reg;
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    tl_next         = tl_reg;
    width_next      = width_reg;
    pd_cnt_next     = pd_cnt_reg;
    pd_next         = pd_reg;
    out_next        = out_reg;
    oe_next         = oe_reg;
    in_q_next       = chain_lvl;
    if (!strap_done_reg)
    begin
      // Straps are caught once, on the first edge after reset release.
      strap_done_next = 1'b1;
      mode_next       = link.op_mode_sel;
      rate_next       = link.rate_sel_chain_in;
      oe_next         = (link.op_mode_sel != PWMTC_PIN_LO);  // Whole first high is driven.
      unique case (link.op_mode_sel)
        PWMTC_PIN_LO: state_next = PWMTC_S_IDLE;
        PWMTC_PIN_HI: state_next = PWMTC_S_PASS;
        default:      state_next = PWMTC_S_HIGH;
      endcase
    end
    else
    begin
      unique case (state_reg)
        PWMTC_S_IDLE:
        begin
          // Line released; a low of at least the minimum width, then release, starts.
          oe_next = 1'b0;
          out_next = 1'b1;
          if (!link.line)
          begin
            cnt_next = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + 32'h0000_0001;
          end
          else
          begin
            cnt_next = 32'h0000_0000;
            if (cnt_reg >= START_MIN_CYC)
            begin
              state_next = PWMTC_S_HIGH;
              oe_next    = 1'b1;
            end
          end
        end
        PWMTC_S_HIGH:
        begin
          oe_next  = 1'b1;
          out_next = 1'b1;
          cnt_next = cnt_reg + 32'h0000_0001;
          if (cnt_reg + 32'h0000_0001 >= th_cyc)
          begin
            state_next = PWMTC_S_LOW;
            cnt_next   = 32'h0000_0000;
            tl_next    = tl_scaled;
            out_next   = 1'b0;
          end
        end
        PWMTC_S_LOW:
        begin
          out_next = 1'b0;
          cnt_next = cnt_reg + 32'h0000_0001;
          if (cnt_reg + 32'h0000_0001 >= tl_reg)
          begin
            cnt_next = 32'h0000_0000;
            out_next = 1'b1;
            if (is_chain)
            begin
              state_next = PWMTC_S_START;
            end
            else if (mode_reg == PWMTC_PIN_LO)
            begin
              state_next = PWMTC_S_IDLE;
              oe_next    = 1'b0;
            end
            else
            begin
              state_next = PWMTC_S_HIGH;
            end
          end
        end
        PWMTC_S_START:
        begin
          // Downstream start pulse after the own reading.
          out_next = 1'b1;
          cnt_next = cnt_reg + 32'h0000_0001;
          if (cnt_reg + 32'h0000_0001 >= START_OUT_CYC)
          begin
            state_next = PWMTC_S_PASS;
            cnt_next   = 32'h0000_0000;
            out_next   = chain_lvl;
          end
        end
        PWMTC_S_PASS:
        begin
          // Input level is relayed to the output.
          oe_next  = 1'b1;
          out_next = chain_lvl;
          if (chain_lvl)
          begin
            width_next  = (width_reg == CNT_MAX) ? width_reg : width_reg + 32'h0000_0001;
            pd_cnt_next = (pd_cnt_reg == CNT_MAX) ? pd_cnt_reg : pd_cnt_reg + 32'h0000_0001;
            if (pd_cnt_reg + 32'h0000_0001 >= PD_CYC)
            begin
              pd_next = 1'b1;
            end
          end
          else
          begin
            width_next  = 32'h0000_0000;
            pd_cnt_next = 32'h0000_0000;
            // Short high just ended: the upstream start pulse. Own high continues it.
            if (in_q_reg && width_reg >= START_MIN_CYC && width_reg < START_MAX_CYC)
            begin
              state_next = PWMTC_S_HIGH;
              cnt_next   = 32'h0000_0000;
              out_next   = 1'b1;
              pd_next    = 1'b0;
            end
          end
        end
      endcase
    end
    conv_next = (state_next == PWMTC_S_HIGH) || (state_next == PWMTC_S_LOW) ||
                (state_next == PWMTC_S_START);
  end

  // Registers the sequencer state.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_done_reg <= 1'b0;
      mode_reg       <= PWMTC_PIN_FL;
      rate_reg       <= PWMTC_PIN_FL;
      state_reg      <= PWMTC_S_IDLE;
      cnt_reg        <= 32'h0000_0000;
      tl_reg         <= 32'h0000_0001;
      width_reg      <= 32'h0000_0000;
      pd_cnt_reg     <= 32'h0000_0000;
      pd_reg         <= 1'b0;
      out_reg        <= 1'b1;
      oe_reg         <= 1'b0;
      in_q_reg       <= 1'b0;
      conv_reg       <= 1'b0;
    end
    else
    begin
      strap_done_reg <= strap_done_next;
      mode_reg       <= mode_next;
      rate_reg       <= rate_next;
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      tl_reg         <= tl_next;
      width_reg      <= width_next;
      pd_cnt_reg     <= pd_cnt_next;
      pd_reg         <= pd_next;
      out_reg        <= out_next;
      oe_reg         <= oe_next;
      in_q_reg       <= in_q_next;
      conv_reg       <= conv_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Drives the link and status from registers.
  assign link.dev_out  = out_reg;
  assign link.dev_oe   = oe_reg;
  assign mode_seen     = mode_reg;
  assign rate_seen     = rate_reg;
  assign converting    = conv_reg;
  assign powered_down  = pd_reg;

endmodule

// >>> rtl/pwmtc_host.sv
/*
  Host end: drives straps, requests readings, times periods and
  queues them in a two-entry buffer.
  Assumes one sensor on the line and a user that drains a word per reading period.
*/
`timescale 1ns/1ns
`include "pwmtc_consts.svh"

module pwmtc_host (
  // Clock and reset.
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // Link to the sensor.
  pwmtc_if.host                      link,
  // Strap settings.
  input  wire pwmtc_pkg::pwmtc_pin_t strap_mode,
  input  wire pwmtc_pkg::pwmtc_pin_t strap_rate,
  // Reading request.
  input  wire logic                  req_valid,
  output logic                       req_ready,
  // Reading out.
  output logic                       rd_valid,
  input  wire logic                  rd_ready,
  output logic [31:0]                rd_high,
  output logic [31:0]                rd_low
);
  import pwmtc_pkg::*;

  localparam logic [31:0] PULL_CYC  = 32'(`PWMTC_PULL_CYC);
  localparam logic [31:0] PRE_CYC   = 32'(`PWMTC_HOST_PRE_CYC);
  localparam logic [31:0] PULSE_CYC = 32'(`PWMTC_HOST_PULSE_CYC);
  localparam logic [31:0] SHORT_CYC = 32'(`PWMTC_START_MAX_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // State.

  pwmtc_hstate_t st_reg;
  pwmtc_hstate_t st_next;
  logic [31:0]   cnt_reg;
  logic [31:0]   cnt_next;
  logic          drv_oe_reg;
  logic          drv_oe_next;
  pwmtc_pin_t    mode_reg;
  pwmtc_pin_t    rate_reg;
  pwmtc_pin_t    rate_next;
  logic          rdy_reg;
  logic          rdy_next;
  logic          line_q_reg;
  logic          have_th_reg;
  logic          have_th_next;
  logic [31:0]   hcnt_reg;
  logic [31:0]   hcnt_next;
  logic [31:0]   lcnt_reg;
  logic [31:0]   lcnt_next;
  logic [31:0]   th_reg;
  logic [31:0]   th_next;
  logic          hv_reg;
  logic          hv_next;
  logic [63:0]   hd_reg;
  logic [63:0]   hd_next;
  logic          sv_reg;
  logic          sv_next;
  logic [63:0]   sd_reg;
  logic [63:0]   sd_next;
  logic          push;
  logic          marker;

  //////////////////////////////////////////////////////////////////////////////
  // Period measurement and buffer.

  // Times high and low periods; short highs are chain-end markers.
  always_comb
  begin
    have_th_next = have_th_reg;
    hcnt_next    = hcnt_reg + 32'h0000_0001;
    lcnt_next    = lcnt_reg + 32'h0000_0001;
    th_next      = th_reg;
    push         = 1'b0;
    marker       = 1'b0;
    if (drv_oe_reg || st_reg == PWMTC_H_PRE)  // Lead-in low is no reading.
    begin
      have_th_next = 1'b0;
    end
    else if (link.line && !line_q_reg)
    begin
      push         = have_th_reg;
      have_th_next = 1'b0;
      hcnt_next    = 32'h0000_0001;
    end
    else if (!link.line && line_q_reg)
    begin
      lcnt_next = 32'h0000_0001;
      if (hcnt_reg < SHORT_CYC)
      begin
        marker = 1'b1;
      end
      else
      begin
        th_next      = hcnt_reg;
        have_th_next = 1'b1;
      end
    end
    // Two-entry buffer: head feeds the user, spare absorbs a stalled word.
    hv_next = hv_reg;
    hd_next = hd_reg;
    sv_next = sv_reg;
    sd_next = sd_reg;
    if (hv_reg && rd_ready)
    begin
      hv_next = sv_reg;
      hd_next = sd_reg;
      sv_next = 1'b0;
    end
    if (push && !hv_next)
    begin
      hv_next = 1'b1;
      hd_next = {th_reg, lcnt_reg};
    end
    else if (push && !sv_next)
    begin
      sv_next = 1'b1;
      sd_next = {th_reg, lcnt_reg};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request sequencer.

  // Issues single-shot pulls and chain start pulses.
  always_comb
  begin
    st_next     = st_reg;
    cnt_next    = cnt_reg + 32'h0000_0001;
    drv_oe_next = 1'b0;
    rate_next   = rate_reg;
    unique case (st_reg)
      PWMTC_H_IDLE:
      begin
        cnt_next = 32'h0000_0000;
        // Idle chain input stays high.
        rate_next = (mode_reg == PWMTC_PIN_HI) ? PWMTC_PIN_HI : strap_rate;
        if (req_valid && rdy_reg)
        begin
          if (mode_reg == PWMTC_PIN_LO)
          begin
            st_next     = PWMTC_H_PULL;
            drv_oe_next = 1'b1;
          end
          else
          begin
            st_next   = PWMTC_H_PRE;
            rate_next = PWMTC_PIN_LO;
          end
        end
      end
      PWMTC_H_PULL:
      begin
        // Line held low beyond the minimum width, then released.
        drv_oe_next = 1'b1;
        if (cnt_reg + 32'h0000_0001 >= PULL_CYC)
        begin
          st_next     = PWMTC_H_WAIT;
          drv_oe_next = 1'b0;
        end
      end
      PWMTC_H_PRE:
      begin
        if (cnt_reg + 32'h0000_0001 >= PRE_CYC)
        begin
          st_next   = PWMTC_H_PULSE;
          cnt_next  = 32'h0000_0000;
          rate_next = PWMTC_PIN_HI;
        end
      end
      PWMTC_H_PULSE:
      begin
        if (cnt_reg + 32'h0000_0001 >= PULSE_CYC)
        begin
          st_next   = PWMTC_H_WAIT;
          rate_next = PWMTC_PIN_LO;
        end
      end
      PWMTC_H_WAIT:
      begin
        if ((mode_reg == PWMTC_PIN_LO && push) || (mode_reg == PWMTC_PIN_HI && marker))
        begin
          st_next   = PWMTC_H_IDLE;
          rate_next = (mode_reg == PWMTC_PIN_HI) ? PWMTC_PIN_HI : strap_rate;
        end
      end
    endcase
    rdy_next = (st_next == PWMTC_H_IDLE) && (mode_reg != PWMTC_PIN_FL) && !hv_next && !sv_next;
  end

  // Registers sequencer, measurement and buffer state.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg      <= PWMTC_H_IDLE;
      cnt_reg     <= 32'h0000_0000;
      drv_oe_reg  <= 1'b0;
      mode_reg    <= PWMTC_PIN_FL;
      rate_reg    <= PWMTC_PIN_FL;
      rdy_reg     <= 1'b0;
      line_q_reg  <= 1'b1;
      have_th_reg <= 1'b0;
      hcnt_reg    <= 32'h0000_0000;
      lcnt_reg    <= 32'h0000_0000;
      th_reg      <= 32'h0000_0000;
      hv_reg      <= 1'b0;
      hd_reg      <= 64'h0000_0000_0000_0000;
      sv_reg      <= 1'b0;
      sd_reg      <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
      drv_oe_reg  <= drv_oe_next;
      mode_reg    <= strap_mode;
      rate_reg    <= rate_next;
      rdy_reg     <= rdy_next;
      line_q_reg  <= link.line;
      have_th_reg <= have_th_next;
      hcnt_reg    <= hcnt_next;
      lcnt_reg    <= lcnt_next;
      th_reg      <= th_next;
      hv_reg      <= hv_next;
      hd_reg      <= hd_next;
      sv_reg      <= sv_next;
      sd_reg      <= sd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Drives link and user side from registers; host_out is tied low.
  assign link.host_out          = 1'b0;
  assign link.host_oe           = drv_oe_reg;
  assign link.op_mode_sel       = mode_reg;
  assign link.rate_sel_chain_in = rate_reg;
  assign req_ready              = rdy_reg;
  assign rd_valid               = hv_reg;
  assign rd_high                = hd_reg[63:32];
  assign rd_low                 = hd_reg[31:0];

endmodule

// >>> bench/pwmtc_props.sv
/*
  Checks on the link signals between host and sensor.
  Assumes the sensor's clock and reset.
*/
`timescale 1ns/1ns
`include "pwmtc_consts.svh"

module pwmtc_props #(
  parameter int unsigned TH_QTR_CYC = 32'h0000_0bb8,
  parameter int unsigned TH_NOM_CYC = 32'h0000_2ee0,
  parameter int unsigned TH_DBL_CYC = 32'h0000_5dc0,
  parameter int unsigned TL_NOM     = 32'h0000_0fa0
) (
  // Clock and reset.
  input wire logic                  clock,
  input wire logic                  rst_n,
  // Line drivers.
  input wire logic                  dev_out,
  input wire logic                  dev_oe,
  input wire logic                  host_out,
  input wire logic                  host_oe,
  // Straps and chain input.
  input wire pwmtc_pkg::pwmtc_pin_t op_mode_sel,
  input wire pwmtc_pkg::pwmtc_pin_t rate_sel_chain_in
);
  import pwmtc_pkg::*;
  logic        drv_hi, drv_lo, rate_hi, in_chain;
  logic        hi_q_reg, lo_q_reg, after_low_reg;
  logic [31:0] hi_cnt_reg, lo_cnt_reg, rhi_cnt_reg, th_exp, tl_exp;

  ////////////////////////////////////////////////////////////
  // Decoded drive levels and the periods expected for the straps.
  assign drv_hi   = dev_oe && dev_out;
  assign drv_lo   = dev_oe && !dev_out;
  assign rate_hi  = rate_sel_chain_in == PWMTC_PIN_HI;
  assign in_chain = op_mode_sel == PWMTC_PIN_HI;
  assign th_exp   = rate_sel_chain_in == PWMTC_PIN_LO ? TH_QTR_CYC :
                    rate_hi ? TH_DBL_CYC : TH_NOM_CYC;
  assign tl_exp   = (in_chain || rate_sel_chain_in == PWMTC_PIN_FL) ? TL_NOM : TL_NOM >> 2;

  // Run lengths; after_low marks the high after the sensor's own low.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_cnt_reg    <= 32'h0000_0000;
      lo_cnt_reg    <= 32'h0000_0000;
      rhi_cnt_reg   <= 32'h0000_0000;
      hi_q_reg      <= 1'b0;
      lo_q_reg      <= 1'b0;
      after_low_reg <= 1'b0;
    end
    else
    begin
      hi_cnt_reg    <= drv_hi ? hi_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
      lo_cnt_reg    <= drv_lo ? lo_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
      rhi_cnt_reg   <= rate_hi ? rhi_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
      hi_q_reg      <= drv_hi;
      lo_q_reg      <= drv_lo;
      after_low_reg <= (lo_q_reg && drv_hi && !rate_hi) || (after_low_reg && drv_hi);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Pull of three cycles; the sensor answers soon after release.
  sequence s_pull_held;
    host_oe [*3] ##1 !host_oe;
  endsequence
  sequence s_dev_answers;
    ##[1:3] drv_hi;
  endsequence

  chk_open_drain: assert property (host_oe |-> !host_out)
    else $error("host drove high");
  chk_pull_len: assert property ($rose(host_oe) |-> s_pull_held)
    else $error("pull length wrong");
  chk_shot_answer: assert property (
    op_mode_sel == PWMTC_PIN_LO && $fell(host_oe) |-> s_dev_answers)
    else $error("no reply to pull");
  chk_high_fixed: assert property (
    hi_q_reg && drv_lo && !in_chain |-> hi_cnt_reg == th_exp)
    else $error("high period wrong");
  chk_low_len: assert property (
    lo_q_reg && dev_out && !(in_chain && rate_hi) |-> lo_cnt_reg == tl_exp)
    else $error("low period wrong");
  chk_shot_release: assert property (
    lo_q_reg && dev_out && op_mode_sel == PWMTC_PIN_LO |-> !dev_oe [*4])
    else $error("line not released");
  chk_start_out: assert property (
    after_low_reg && !drv_hi && in_chain |-> hi_cnt_reg == `PWMTC_START_OUT_CYC)
    else $error("start pulse out wrong");
  chk_host_start: assert property (
    $fell(rate_hi) && rhi_cnt_reg < 2500 |-> rhi_cnt_reg == `PWMTC_HOST_PULSE_CYC)
    else $error("start pulse in wrong");
endmodule

// >>> bench/testbench.sv
/*
  Self-checking bench: host, sensor and checker on one link.
  Assumes shortened periods and a fixed modulator result.
*/
`timescale 1ns/1ns
module testbench;
  import pwmtc_pkg::*;
  localparam int unsigned TQ = 32'h0000_0bb8, TN = 32'h0000_2ee0, TD = 32'h0000_5dc0,
                          TL = 32'h0000_0fa0;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        s_rst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic        rd_ready = 1'b0;
  pwmtc_pin_t  smode = PWMTC_PIN_LO;
  pwmtc_pin_t  srate = PWMTC_PIN_LO;
  pwmtc_pin_t  mode_seen, rate_seen;
  logic        req_ready, rd_valid, converting, powered_down;
  logic [31:0] rd_high, rd_low;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;

  pwmtc_if link ();
  pwmtc_sensor #(.TH_QTR_CYC(TQ), .TH_NOM_CYC(TN), .TH_DBL_CYC(TD), .PD_CYC(32'h0000_07d0))
    i_pwmtc_sensor (.clock(clock), .rst_n(s_rst_n), .link(link.sensor), .temp_tl_nom(TL),
    .mode_seen(mode_seen), .rate_seen(rate_seen), .converting(converting),
    .powered_down(powered_down));
  pwmtc_host i_pwmtc_host (.clock(clock), .rst_n(rst_n), .link(link.host), .strap_mode(smode),
    .strap_rate(srate), .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .rd_high(rd_high), .rd_low(rd_low));
  pwmtc_props #(.TH_QTR_CYC(TQ), .TH_NOM_CYC(TN), .TH_DBL_CYC(TD), .TL_NOM(TL)) i_props (
    .clock(clock), .rst_n(s_rst_n), .dev_out(link.dev_out), .dev_oe(link.dev_oe),
    .host_out(link.host_out), .host_oe(link.host_oe), .op_mode_sel(link.op_mode_sel),
    .rate_sel_chain_in(link.rate_sel_chain_in));

  ////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling that cuts a hang short.
  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      failures++;
      wrap_up();
    end
  end

  // Prints the counts and the verdict, then ends.
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compares a value with a range.
  task automatic check(input logic [31:0] got, lo, hi);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      failures++;
      $display("[FAIL] %0t got %h want %h..%h", $time, got, lo, hi);
    end
  endtask

  // Waits edges, then steps just past the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Resets with the given straps; host first, so straps settle.
  task automatic start(input pwmtc_pin_t m, r);
    rst_n = 1'b0;
    s_rst_n = 1'b0;
    smode = m;
    srate = r;
    tick(16);
    rst_n = 1'b1;
    tick(2);
    s_rst_n = 1'b1;
    tick(2);
    check(32'(mode_seen), 32'(m), 32'(m));
    if (m != PWMTC_PIN_HI)
      check(32'(rate_seen), 32'(r), 32'(r));
  endtask

  // Holds a request until it is taken.
  task automatic request();
    req_valid = 1'b1;
    for (int k = 0; k < 20 && req_ready !== 1'b1; k++) tick(1);
    tick(1);
    req_valid = 1'b0;
  endtask

  // Waits for a word, judges it and drains it.
  task automatic get(input logic [31:0] h0, h1, l0, l1);
    for (int k = 0; k < 30000 && rd_valid !== 1'b1; k++) tick(1);
    check(32'(rd_valid), 1, 1);
    check(rd_high, h0, h1);
    check(rd_low, l0, l1);
    rd_ready = 1'b1;
    tick(1);
    rd_ready = 1'b0;
    tick(1);
  endtask

  // One requested reading, then the line is released.
  task automatic one_shot(input pwmtc_pin_t r, input logic [31:0] th, tl);
    start(PWMTC_PIN_LO, r);
    request();
    get(th - 2, th + 2, tl - 2, tl + 2);
    tick(4);
    check(32'(link.line), 1, 1);
    check(32'(converting), 0, 0);
  endtask

  // Stalled reader keeps two words; the first high counts from host reset, 3 cycles early.
  task automatic stream_fill();
    start(PWMTC_PIN_FL, PWMTC_PIN_LO);
    tick(17000);
    get(TQ + 1, TQ + 5, TL / 4 - 2, TL / 4 + 2);
    get(TQ - 2, TQ + 2, TL / 4 - 2, TL / 4 + 2);
    check(32'(rd_valid), 0, 0);
  endtask

  // Chain readout: relay, one reading, start pulse, power-down.
  task automatic chain_run();
    start(PWMTC_PIN_HI, PWMTC_PIN_LO);
    tick(3000);
    check(32'(link.line), 1, 1);
    check(32'(powered_down), 1, 1);
    request();
    tick(200);
    check(32'(converting), 1, 1);
    check(32'(powered_down), 0, 0);
    get(TN, TN + 110, TL - 2, TL + 2);
    for (int k = 0; k < 5000 && req_ready !== 1'b1; k++) tick(1);
    check(32'(req_ready), 1, 1);
    tick(2100);
    check(32'(powered_down), 1, 1);
  endtask

  // Main sequence.
  initial
  begin
    one_shot(PWMTC_PIN_LO, TQ, TL >> 2);
    one_shot(PWMTC_PIN_FL, TN, TL);
    one_shot(PWMTC_PIN_HI, TD, TL >> 2);
    stream_fill();
    chain_run();
    wrap_up();
  end
endmodule
